// *** hdl/edr_denoiser.sv ***
// edge-adaptive 4:4:4 video denoiser with host register set
`timescale 1ns/100ps
`include "edr_cfg.svh"

module edr_denoiser #(
    parameter int DATA_W = 8,
    parameter int MAX_COLS = 4096,
    parameter int MAX_ROWS = 4096,
    parameter logic [2:0] DEF_LEVEL = 3'h2,
    parameter int EDGE_SHIFT = DATA_W - 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`EDR_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [3*DATA_W-1:0] video_data_in,
    input wire logic vblank_in,
    input wire logic hblank_in,
    input wire logic active_video_in,
    output logic [3*DATA_W-1:0] video_data_out,
    output logic vblank_out,
    output logic hblank_out,
    output logic active_video_out
);

    localparam int PW = 3 * DATA_W;
    localparam int COL_W = $clog2(MAX_COLS);
    localparam int ROW_W = $clog2(MAX_ROWS);
    localparam int NT = `EDR_TAPS;

    // ---------------- host registers ----------------
    logic [1:0] ctrl_r;
    logic srst_r;
    logic [2:0] shadow_r;
    logic [2:0] work_r;
    edr_pkg::edr_lock_t lock_r;
    logic enable;
    logic wr_done;
    logic vb_rise;

    assign enable = ctrl_r[`EDR_CTRL_EN_BIT];
    assign wr_done = ctrl_r[`EDR_CTRL_DONE_BIT];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `EDR_CTRL_RESET;
        end else if (reg_wr_en && reg_addr == `EDR_OFS_CTRL) begin
            ctrl_r <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            srst_r <= `EDR_SRST_RESET;
        end else if (reg_wr_en && reg_addr == `EDR_OFS_SRST) begin
            srst_r <= reg_wdata[`EDR_SRST_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shadow_r <= DEF_LEVEL;
        end else if (srst_r) begin
            shadow_r <= DEF_LEVEL;
        end else if (reg_wr_en && reg_addr == `EDR_OFS_LEVEL) begin
            shadow_r <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            work_r <= DEF_LEVEL;
        end else if (srst_r) begin
            work_r <= DEF_LEVEL;
        end else if (vb_rise && wr_done && enable) begin
            work_r <= shadow_r;
        end
    end

    // reads answer one cycle later with a pulse on reg_rvalid
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd_en;
            if (reg_rd_en) begin
                unique case (reg_addr)
                    `EDR_OFS_CTRL: reg_rdata <= {30'h0000_0000, ctrl_r};
                    `EDR_OFS_SRST: reg_rdata <= {31'h0000_0000, srst_r};
                    `EDR_OFS_STAT: reg_rdata <= {24'h00_0000, lock_r == edr_pkg::LK_LOCKED, 7'h00};
                    `EDR_OFS_LEVEL: reg_rdata <= {29'h0000_0000, shadow_r};
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------- input stage ----------------
    edr_pkg::edr_timing_t in_tm_r;
    logic [PW-1:0] in_pix_r;
    logic vb_prev_r;
    logic act_prev_r;
    logic run;

    assign run = enable && !srst_r;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            in_tm_r <= '0;
            in_pix_r <= '0;
        end else if (!run) begin
            in_tm_r <= '0;
            in_pix_r <= '0;
        end else begin
            in_tm_r <= '{vblank: vblank_in, hblank: hblank_in, active: active_video_in};
            in_pix_r <= video_data_in;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vb_prev_r <= 1'b0;
            act_prev_r <= 1'b0;
        end else begin
            vb_prev_r <= in_tm_r.vblank;
            act_prev_r <= in_tm_r.active;
        end
    end

    assign vb_rise = in_tm_r.vblank && !vb_prev_r;

    // ---------------- pixel and line position ----------------
    logic [COL_W-1:0] col_r;
    logic [ROW_W-1:0] row_r;
    logic line_end;

    assign line_end = act_prev_r && !in_tm_r.active;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            col_r <= '0;
        end else if (!in_tm_r.active) begin
            col_r <= '0;
        end else if (col_r != COL_W'(MAX_COLS - 1)) begin
            col_r <= col_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            row_r <= '0;
        end else if (in_tm_r.vblank) begin
            row_r <= '0;
        end else if (line_end && row_r != ROW_W'(MAX_ROWS - 1)) begin
            row_r <= row_r + 1'b1;
        end
    end

    // ---------------- timing lock ----------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lock_r <= edr_pkg::LK_IDLE;
        end else if (!run) begin
            lock_r <= edr_pkg::LK_IDLE;
        end else if (vb_rise) begin
            unique case (lock_r)
                edr_pkg::LK_IDLE: lock_r <= edr_pkg::LK_SEEN;
                edr_pkg::LK_SEEN: lock_r <= (row_r != '0) ? edr_pkg::LK_LOCKED : edr_pkg::LK_SEEN;
                edr_pkg::LK_LOCKED: lock_r <= edr_pkg::LK_LOCKED;
            endcase
        end
    end

    // ---------------- line buffers ----------------
    logic [PW-1:0] line_up [0:MAX_COLS-1];
    logic [PW-1:0] line_up2 [0:MAX_COLS-1];
    logic [PW-1:0] rd_up;
    logic [PW-1:0] rd_up2;

    assign rd_up = line_up[col_r];
    assign rd_up2 = line_up2[col_r];

    // previous line moves down one buffer as the new one is written
    always_ff @(posedge core_clk) begin
        if (in_tm_r.active) begin
            line_up[col_r] <= in_pix_r;
            line_up2[col_r] <= rd_up;
        end
    end

    // ---------------- column taps ----------------
    logic [PW-1:0] bot_t [0:NT-1];
    logic [PW-1:0] mid_t [0:NT-1];
    logic [PW-1:0] top_t [0:NT-1];
    logic [NT-1:0] first_sr;
    logic [PW-1:0] mid_in;
    logic [PW-1:0] top_in;

    // rows not yet seen in this frame repeat the nearest real row
    assign mid_in = (row_r != '0) ? rd_up : in_pix_r;
    assign top_in = (row_r > ROW_W'(1)) ? rd_up2 : mid_in;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            first_sr <= '0;
            for (int i = 0; i < NT; i++) begin
                bot_t[i] <= '0;
                mid_t[i] <= '0;
                top_t[i] <= '0;
            end
        end else begin
            first_sr <= {first_sr[NT-2:0], in_tm_r.active && col_r == '0};
            for (int i = 1; i < NT; i++) begin
                bot_t[i] <= bot_t[i-1];
                mid_t[i] <= mid_t[i-1];
                top_t[i] <= top_t[i-1];
            end
            // outside active video the newest pixel repeats, replicating the right border
            if (in_tm_r.active) begin
                bot_t[0] <= in_pix_r;
                mid_t[0] <= mid_in;
                top_t[0] <= top_in;
            end
        end
    end

    // ---------------- window with left border replication ----------------
    logic [PW-1:0] win_pix [0:2][0:NT-1];

    always_comb begin
        for (int c = 0; c < NT; c++) begin
            win_pix[0][c] = top_t[NT-1-c];
            win_pix[1][c] = mid_t[NT-1-c];
            win_pix[2][c] = bot_t[NT-1-c];
        end
        if (first_sr[2]) begin
            for (int r = 0; r < 3; r++) begin
                win_pix[r][0] = win_pix[r][2];
                win_pix[r][1] = win_pix[r][2];
            end
        end else if (first_sr[3]) begin
            for (int r = 0; r < 3; r++) begin
                win_pix[r][0] = win_pix[r][1];
            end
        end
    end

    // ---------------- edge gain from luma ----------------
    logic [DATA_W-1:0] l_left;
    logic [DATA_W-1:0] l_right;
    logic [DATA_W-1:0] l_up;
    logic [DATA_W-1:0] l_down;
    logic [DATA_W:0] grad_h;
    logic [DATA_W:0] grad_v;
    logic [DATA_W+1:0] grad;
    logic [DATA_W+1:0] grad_q;
    logic [`EDR_GAIN_W-1:0] gain;

    assign l_left = win_pix[1][1][DATA_W-1:0];
    assign l_right = win_pix[1][3][DATA_W-1:0];
    assign l_up = win_pix[0][2][DATA_W-1:0];
    assign l_down = win_pix[2][2][DATA_W-1:0];

    assign grad_h = (l_left > l_right) ? {1'b0, l_left - l_right} : {1'b0, l_right - l_left};
    assign grad_v = (l_up > l_down) ? {1'b0, l_up - l_down} : {1'b0, l_down - l_up};
    assign grad = {1'b0, grad_h} + {1'b0, grad_v};
    assign grad_q = grad >> EDGE_SHIFT;

    // strong edges drive the gain toward zero, leaving the pixel untouched
    always_comb begin
        if (grad_q >= (DATA_W+2)'(`EDR_GAIN_ONE)) begin
            gain = '0;
        end else begin
            gain = `EDR_GAIN_ONE - grad_q[`EDR_GAIN_W-1:0];
        end
    end

    // ---------------- per-component filters ----------------
    logic [PW-1:0] filt_pix;

    genvar gc;
    generate
        for (gc = 0; gc < 3; gc++) begin : g_comp
            logic [15*DATA_W-1:0] comp_win;
            always_comb begin
                for (int r = 0; r < 3; r++) begin
                    for (int c = 0; c < NT; c++) begin
                        comp_win[(r*NT+c)*DATA_W +: DATA_W] = win_pix[r][c][gc*DATA_W +: DATA_W];
                    end
                end
            end
            edr_comp_filter #(
                .W(DATA_W)
            ) u_filt (
                .core_clk(core_clk),
                .nrst(nrst),
                .win(comp_win),
                .level(work_r),
                .gain(gain),
                .pix_out(filt_pix[gc*DATA_W +: DATA_W])
            );
        end
    endgenerate

    // ---------------- timing alignment ----------------
    edr_pkg::edr_timing_t tm_sr [0:`EDR_TM_DELAY-1];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `EDR_TM_DELAY; i++) begin
                tm_sr[i] <= '0;
            end
        end else begin
            tm_sr[0] <= in_tm_r;
            for (int i = 1; i < `EDR_TM_DELAY; i++) begin
                tm_sr[i] <= tm_sr[i-1];
            end
        end
    end

    // ---------------- outputs ----------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            video_data_out <= '0;
            vblank_out <= 1'b0;
            hblank_out <= 1'b0;
            active_video_out <= 1'b0;
        end else if (!run) begin
            video_data_out <= '0;
            vblank_out <= 1'b0;
            hblank_out <= 1'b0;
            active_video_out <= 1'b0;
        end else begin
            video_data_out <= tm_sr[`EDR_TM_DELAY-1].active ? filt_pix : '0;
            vblank_out <= tm_sr[`EDR_TM_DELAY-1].vblank;
            hblank_out <= tm_sr[`EDR_TM_DELAY-1].hblank;
            active_video_out <= tm_sr[`EDR_TM_DELAY-1].active;
        end
    end

endmodule : edr_denoiser

// *** hdl/edr_cfg.svh ***
// register offsets, field positions, reset values and timing counts for the denoiser
// Notes on behaviour
// - smoothing contribution of each pixel is weighted by a gain from local edge content
// - gain drops where edges are found, so edges get less smoothing than flat areas
// - smoothing level 0 to 4; 1 weakest, 4 strongest, 0 passes pixels through
// - level 1 uses 3x3 kernel rows 1 2 1, 1 6 1, 1 2 1
// - level 2 uses 3x3 kernel rows 1 2 1, 2 4 2, 1 2 1
// - level 3 uses 3x5 kernel rows 0 1 1 1 0, 1 2 4 2 1, 0 1 1 1 0
// - level 4 uses 3x5 kernel rows 0 1 2 1 0, 1 2 2 2 1, 0 1 2 1 0
// - component width 8, 10 or 12 bits per instance, same on input and output
// - frames up to 4096 pixels per line and 4096 lines
// - both streams carry full 4:4:4 luma plus two chroma per pixel
// - enable bit 0 cleared stops all video propagating; it resets to set
// - vblank rising edge copies shadow to working only while write-done bit 1 is 1
// - level write updates shadow at once; filtering uses working copy until transfer
// - reads return the shadow copy of double-buffered parameters
// - while soft reset bit 0 is 1, video data and timing outputs are held at 0
// - soft reset returns the level to instance default immediately
// - status bit 7 set once timing has locked to the incoming frames
// - every register is readable, including written ones
// - registers are memory mapped from offset 0x800
// - shadow to working transfer only happens while enable is set
// - each video link is data bus plus vblank, hblank and active-video
`ifndef EDR_CFG_SVH
`define EDR_CFG_SVH

`define EDR_ADDR_W 12
`define EDR_OFS_CTRL 12'h0800
`define EDR_OFS_SRST 12'h0804
`define EDR_OFS_STAT 12'h0808
`define EDR_OFS_LEVEL 12'h080C

`define EDR_CTRL_EN_BIT 0
`define EDR_CTRL_DONE_BIT 1
`define EDR_SRST_BIT 0
`define EDR_STAT_LOCK_BIT 7

`define EDR_CTRL_RESET 2'h1
`define EDR_SRST_RESET 1'h0

`define EDR_LEVEL_W 3
`define EDR_LEVEL_MAX 3'h4

`define EDR_KSUM_SHIFT 4
`define EDR_GAIN_W 5
`define EDR_GAIN_ONE 5'h10
`define EDR_GAIN_FRAC 4

`define EDR_TM_DELAY 4
`define EDR_TAPS 5

`endif

// *** hdl/edr_pkg.sv ***
// types shared by the denoiser modules
package edr_pkg;

    typedef struct packed {
        logic vblank;
        logic hblank;
        logic active;
    } edr_timing_t;

    typedef enum logic [1:0] {
        LK_IDLE,
        LK_SEEN,
        LK_LOCKED
    } edr_lock_t;

endpackage : edr_pkg

// *** hdl/edr_comp_filter.sv ***
// one colour component: kernel smoothing, normalisation and edge-gain blend
`timescale 1ns/100ps
`include "edr_cfg.svh"

module edr_comp_filter #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [15*W-1:0] win,
    input wire logic [`EDR_LEVEL_W-1:0] level,
    input wire logic [`EDR_GAIN_W-1:0] gain,
    output logic [W-1:0] pix_out
);

    // weights, row-major top-left first; every kernel sums to 16
    function automatic logic [2:0] kw(input logic [`EDR_LEVEL_W-1:0] lv, input int idx);
        logic [44:0] tbl;
        tbl = '0;
        unique case (lv)
            3'h1: tbl = {3'h0, 3'h1, 3'h2, 3'h1, 3'h0, 3'h0, 3'h1, 3'h6, 3'h1, 3'h0,
                         3'h0, 3'h1, 3'h2, 3'h1, 3'h0};
            3'h2: tbl = {3'h0, 3'h1, 3'h2, 3'h1, 3'h0, 3'h0, 3'h2, 3'h4, 3'h2, 3'h0,
                         3'h0, 3'h1, 3'h2, 3'h1, 3'h0};
            3'h3: tbl = {3'h0, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h2, 3'h4, 3'h2, 3'h1,
                         3'h0, 3'h1, 3'h1, 3'h1, 3'h0};
            3'h4: tbl = {3'h0, 3'h1, 3'h2, 3'h1, 3'h0, 3'h1, 3'h2, 3'h2, 3'h2, 3'h1,
                         3'h0, 3'h1, 3'h2, 3'h1, 3'h0};
            default: tbl = '0;
        endcase
        kw = tbl[idx*3 +: 3];
    endfunction : kw

    logic [W+2:0] prod [0:14];
    logic [W+4:0] acc;
    logic [W-1:0] orig;
    logic [W-1:0] smooth;
    logic signed [W+1:0] diff;
    logic signed [W+7:0] scaled;
    logic signed [W+7:0] delta;
    logic [W-1:0] blended;

    genvar gi;
    generate
        for (gi = 0; gi < 15; gi++) begin : g_tap
            assign prod[gi] = kw(level, gi) * {3'h0, win[gi*W +: W]};
        end
    endgenerate

    always_comb begin
        acc = '0;
        for (int i = 0; i < 15; i++) begin
            acc = acc + {2'h0, prod[i]};
        end
    end

    assign orig = win[7*W +: W];
    assign smooth = acc[`EDR_KSUM_SHIFT +: W];
    assign diff = $signed({2'h0, smooth}) - $signed({2'h0, orig});
    assign scaled = diff * $signed({1'b0, gain});
    assign delta = scaled >>> `EDR_GAIN_FRAC;
    assign blended = orig + delta[W-1:0];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pix_out <= '0;
        end else if (level == 3'h0 || level > `EDR_LEVEL_MAX) begin
            pix_out <= orig;
        end else begin
            pix_out <= blended;
        end
    end

endmodule : edr_comp_filter

// *** tb/edr_checker.sv ***
// port-level checker for the denoiser, bound to its top module
`timescale 1ns/100ps
`include "edr_cfg.svh"

module edr_checker #(
    parameter int DATA_W = 8,
    parameter logic [2:0] DEF_LEVEL = 3'h2
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`EDR_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [3*DATA_W-1:0] video_data_in,
    input wire logic vblank_in,
    input wire logic hblank_in,
    input wire logic active_video_in,
    input wire logic [3*DATA_W-1:0] video_data_out,
    input wire logic vblank_out,
    input wire logic hblank_out,
    input wire logic active_video_out
);
    logic [1:0] ctrl_r;
    logic srst_r;
    logic [2:0] lvl_r;
    logic [3:0] run_r;
    logic [31:0] exp_rd;
    logic known;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // mirror of host-visible control state
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= 2'h1;
            srst_r <= 1'b0;
        end else if (reg_wr_en) begin
            if (reg_addr == `EDR_OFS_CTRL) ctrl_r <= reg_wdata[1:0];
            if (reg_addr == `EDR_OFS_SRST) srst_r <= reg_wdata[0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) lvl_r <= DEF_LEVEL;
        else if (srst_r) lvl_r <= DEF_LEVEL;
        else if (reg_wr_en && reg_addr == `EDR_OFS_LEVEL) lvl_r <= reg_wdata[2:0];
    end

    // cycles of uninterrupted running, saturating once the pipe is full
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) run_r <= 4'h0;
        else if (!ctrl_r[0] || srst_r) run_r <= 4'h0;
        else if (run_r != 4'h8) run_r <= run_r + 4'h1;
    end

    always_comb begin
        known = 1'b1;
        exp_rd = 32'h0000_0000;
        case (reg_addr)
            `EDR_OFS_CTRL: exp_rd = {30'h0, ctrl_r};
            `EDR_OFS_SRST: exp_rd = {31'h0, srst_r};
            `EDR_OFS_STAT: known = 1'b0;
            `EDR_OFS_LEVEL: exp_rd = {29'h0, lvl_r};
            default: exp_rd = 32'h0000_0000;
        endcase
    end

    sequence rd_cmd;
        reg_rd_en;
    endsequence

    sequence srst_held;
        srst_r ##1 srst_r;
    endsequence

    rd_answer_a: assert property (rd_cmd |=> reg_rvalid) else $error("read not answered");
    rd_quiet_a: assert property (!reg_rd_en |=> !reg_rvalid) else $error("spurious rvalid");
    read_back_a: assert property (rd_cmd ##0 known |=> reg_rdata == $past(exp_rd))
        else $error("register readback wrong");
    stat_bits_a: assert property (rd_cmd ##0 reg_addr == `EDR_OFS_STAT |=> reg_rdata[31:8] == 24'h00_0000
        && reg_rdata[6:0] == 7'h00) else $error("status reserved bits set");
    lock_drop_a: assert property (srst_held ##0 rd_cmd ##0 reg_addr == `EDR_OFS_STAT |=> !reg_rdata[7])
        else $error("lock kept in soft reset");
    tm_delay_a: assert property (run_r == 4'h8 |-> {vblank_out, hblank_out, active_video_out}
        == {$past(vblank_in, 6), $past(hblank_in, 6), $past(active_video_in, 6)}) else $error("timing latency wrong");
    idle_zero_a: assert property (!active_video_out |-> video_data_out == '0)
        else $error("data outside active video");
    srst_zero_a: assert property (srst_r |=> {video_data_out, vblank_out, hblank_out, active_video_out} == '0)
        else $error("outputs live in soft reset");
    off_zero_a: assert property (!ctrl_r[0] |=> {video_data_out, vblank_out, hblank_out, active_video_out} == '0)
        else $error("outputs live while disabled");
endmodule : edr_checker

bind edr_denoiser edr_checker #(.DATA_W(DATA_W), .DEF_LEVEL(DEF_LEVEL)) chk (
    .core_clk(core_clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .video_data_in(video_data_in),
    .vblank_in(vblank_in), .hblank_in(hblank_in), .active_video_in(active_video_in),
    .video_data_out(video_data_out), .vblank_out(vblank_out), .hblank_out(hblank_out),
    .active_video_out(active_video_out)
);

// *** tb/edr_video_src.sv ***
// upstream video source: one flat frame with a single luma bump
`timescale 1ns/100ps

module edr_video_src #(
    parameter int W = 8,
    parameter int COLS = 8,
    parameter int ROWS = 5
) (
    input wire logic core_clk,
    input wire logic start,
    input wire logic [3*W-1:0] base,
    output logic [3*W-1:0] data,
    output edr_pkg::edr_timing_t tm,
    output logic busy
);
    logic [3*W-1:0] junk;
    int r;
    int c;

    // bus carries a changing pattern outside active video
    task automatic tick(input logic v, input logic h, input logic a, input logic [3*W-1:0] d);
        @(negedge core_clk);
        tm.vblank = v;
        tm.hblank = h;
        tm.active = a;
        junk = {junk[3*W-2:0], ~junk[3*W-1]};
        data = a ? d : junk;
    endtask : tick

    initial begin
        tm = '0;
        data = '0;
        junk = '0;
        busy = 1'b0;
        forever begin
            @(posedge start);
            busy = 1'b1;
            for (r = 0; r < 4; r++) tick(1'b1, 1'b1, 1'b0, base);
            for (r = 0; r < ROWS; r++) begin
                for (c = 0; c < COLS; c++) tick(1'b0, 1'b0, 1'b1, (r == 2 && c == 3) ? base + 16 : base);
                for (c = 0; c < 3; c++) tick(1'b0, 1'b1, 1'b0, base);
            end
            busy = 1'b0;
        end
    end
endmodule : edr_video_src

// *** tb/edr_denoiser_tb.sv ***
// self-checking bench for the denoiser
`timescale 1ns/100ps
`include "edr_cfg.svh"

module edr_denoiser_tb;
    localparam int COLS = 8;
    localparam int ROWS = 5;
    localparam logic [2:0] DEF = 3'h2;
    logic core_clk, nrst, reg_wr_en, reg_rd_en, reg_rvalid, start, busy;
    logic vblank_out, hblank_out, active_video_out;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [23:0] base, video_data_in, video_data_out;
    logic [7:0] pk, sd;
    logic [2:0] lv, prev;
    logic [2:0] lvls [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
    edr_pkg::edr_timing_t tm;
    int seed, fail_count, n_tests, n_act, cyc, i;

    edr_denoiser #(.DATA_W(8), .MAX_COLS(64), .MAX_ROWS(64), .DEF_LEVEL(DEF)) dut (
        .core_clk(core_clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .video_data_in(video_data_in),
        .vblank_in(tm.vblank), .hblank_in(tm.hblank), .active_video_in(tm.active),
        .video_data_out(video_data_out), .vblank_out(vblank_out), .hblank_out(hblank_out),
        .active_video_out(active_video_out)
    );

    edr_video_src #(.W(8), .COLS(COLS), .ROWS(ROWS)) src (
        .core_clk(core_clk), .start(start), .base(base), .data(video_data_in), .tm(tm), .busy(busy)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // luma at the bump centre: base plus the kernel's centre weight
    function automatic logic [7:0] peak(input logic [2:0] l, input logic [7:0] b);
        case (l)
            3'h1: return b + 8'h06;
            3'h2, 3'h3: return b + 8'h04;
            3'h4: return b + 8'h02;
            default: return b + 8'h10;
        endcase
    endfunction : peak

    // luma just left of the bump: edge there costs one gain step against flat smoothing
    function automatic logic [7:0] side(input logic [2:0] l, input logic [7:0] b);
        case (l)
            3'h2, 3'h3, 3'h4: return b + 8'h01;
            default: return b;
        endcase
    endfunction : side

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge core_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        @(negedge core_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        check({31'h0, reg_rvalid}, 32'h0000_0001);
        check(reg_rdata, exp);
    endtask : rdc

    task automatic frame(input logic [2:0] l, input logic on);
        int k;
        n_act = 0;
        pk = 8'h00;
        sd = 8'h00;
        base[7:0] = 8'($unsigned($random(seed)) % 200);
        base[23:8] = 16'($random(seed));
        @(negedge core_clk);
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        for (k = 0; k < 200 && busy === 1'b1; k++) @(negedge core_clk);
        repeat (10) @(negedge core_clk);
        check(n_act, on ? COLS * ROWS : 0);
        if (on) check(pk, peak(l, base[7:0]));
        if (on) check(sd, side(l, base[7:0]));
    endtask : frame

    // output monitor: chroma stays flat, track peak luma and luma left of the bump
    always @(negedge core_clk) begin
        cyc++;
        if (active_video_out === 1'b1) begin
            if (n_act == 3 * COLS + 2) sd = video_data_out[7:0];
            n_act++;
            if (video_data_out[7:0] > pk) pk = video_data_out[7:0];
            check(video_data_out[23:8], base[23:8]);
        end
        if (cyc == 10000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        seed = 9883;
        nrst = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0000_0000;
        start = 1'b0;
        base = 24'h00_0000;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        rdc(`EDR_OFS_CTRL, 32'h0000_0001);
        rdc(`EDR_OFS_SRST, 32'h0000_0000);
        rdc(`EDR_OFS_STAT, 32'h0000_0000);
        rdc(`EDR_OFS_LEVEL, {29'h0, DEF});
        rdc(12'h810, 32'h0000_0000);
        rdc(12'h000, 32'h0000_0000);
        frame(DEF, 1'b1);
        frame(DEF, 1'b1);
        rdc(`EDR_OFS_STAT, 32'h0000_0080);
        wr(`EDR_OFS_STAT, 32'hffff_ffff);
        rdc(`EDR_OFS_STAT, 32'h0000_0080);
        prev = DEF;
        for (i = 0; i < 9; i++) begin
            lv = (i < 5) ? lvls[i] : 3'($unsigned($random(seed)) % 6);
            wr(`EDR_OFS_LEVEL, {29'h0, lv});
            rdc(`EDR_OFS_LEVEL, {29'h0, lv});
            frame(prev, 1'b1);
            wr(`EDR_OFS_CTRL, 32'h0000_0003);
            frame(lv, 1'b1);
            wr(`EDR_OFS_CTRL, 32'h0000_0001);
            prev = lv;
        end
        lv = (prev == 3'h1) ? 3'h4 : 3'h1;
        wr(`EDR_OFS_LEVEL, {29'h0, lv});
        wr(`EDR_OFS_CTRL, 32'h0000_0002);
        rdc(`EDR_OFS_CTRL, 32'h0000_0002);
        frame(prev, 1'b0);
        wr(`EDR_OFS_CTRL, 32'h0000_0001);
        frame(prev, 1'b1);
        wr(`EDR_OFS_SRST, 32'h0000_0001);
        rdc(`EDR_OFS_LEVEL, {29'h0, DEF});
        rdc(`EDR_OFS_STAT, 32'h0000_0000);
        frame(DEF, 1'b0);
        wr(`EDR_OFS_SRST, 32'h0000_0000);
        frame(DEF, 1'b1);
        test_done();
    end
endmodule : edr_denoiser_tb
